// ---- verilog/daq_seq_pkg.sv ----
// Shared constants and types for the acquire-and-convert sequencer.
package daq_seq_pkg;

    // Clock and timing.
    localparam int CLK_MHZ = 125;
    localparam int NS_PER_US = 1000;
    localparam int US_CYC = (NS_PER_US * CLK_MHZ) / NS_PER_US;
    localparam int ACQ_BASE_US = 9;
    localparam int ACQ_OHMS_PER_US = 1000;
    localparam int CONV_MAX_NS = 10000;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_MHZ) / NS_PER_US;
    localparam int RES_BITS = 12;
    localparam int CONV_STEP_CYC = CONV_MAX_CYC / RES_BITS;

    // Register byte offsets.
    localparam logic [3:0] REG_CTRL_OFS = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h4;
    localparam logic [3:0] REG_RESULT_OFS = 4'h8;
    localparam logic [3:0] REG_COUNT_OFS = 4'hc;

    // Control register fields.
    localparam int CTRL_BIPOLAR_BIT = 0;
    localparam int CTRL_SOFT_TRIG_BIT = 1;
    localparam int CTRL_ACQ_EXTRA_LSB = 8;
    localparam int ACQ_EXTRA_W = 8;

    // Status register fields.
    localparam int STAT_EOC_BIT = 0;
    localparam int STAT_STATE_LSB = 1;
    localparam int STAT_CHAN_LSB = 4;
    localparam int STAT_MUX_EN_BIT = 8;

    // Result register fields.
    localparam int RES_CHAN_LSB = 16;

    // Reset values.
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic BIPOLAR_RST = 1'b0;
    localparam logic [11:0] BIPOLAR_MSB_MASK = 12'h800;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10
    } seq_state_t;

endpackage

// ---- verilog/tick_divider.sv ----
// Clock-enable divider: one-cycle tick every PERIOD cycles while enabled.
`timescale 1ns/10ps
module tick_divider #(
    parameter int PERIOD = 125
) (
    input wire logic clk_i,   // System clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic en_i,    // Run enable; low restarts the count.
    output logic tick_o       // One-cycle pulse each period.
);
    localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_reg;

    generate
        if (PERIOD < 1) begin : g_bad
            $error("tick_divider PERIOD must be at least 1");
        end
    endgenerate

    // Restarting on enable keeps the first tick a full period after start.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (!en_i || cnt_reg == LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick_o = en_i && (cnt_reg == LAST);
endmodule // tick_divider

// ---- verilog/daq_acquire_convert_sequencer.sv ----
// Acquire-then-convert sequencer with channel addressing and an Avalon-MM register port.
//
// How it works
// - Trigger falling edge starts acquisition, status low.
// - One-shot expiry: hold, clock on, start, status high.
// - Conversion ends within 10 us, status low.
// - Status low: result valid, sampler ready again.
// - Each trigger edge while idle runs one conversion; edges during acquisition or conversion are ignored.
// - Acquisition 9 us plus 1 us per kilohm.
// - Throughput is acquisition plus conversion period.
// - Channel-reset low returns address to channel 0.
// - Current channel address always shown on readback.
// - Unipolar results are straight binary.
// - Bipolar results are offset binary.
// - Address weighting 8,4,2,1; eight channels use three.
// - Load low captures address pins at trigger edge.
// - Sequential mode increments address at trigger edge.
// - Each result nibble driven only while enabled.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module daq_acquire_convert_sequencer
    import daq_seq_pkg::*;
#(
    parameter int NUM_CHAN = 16,
    parameter int ACQ_DELAY_OHMS = 0
) (
    input wire logic CLK_I,                 // System clock, 125 MHz.
    input wire logic RESET_N_I,             // Asynchronous reset, active low.
    input wire logic STROBE_N_I,            // Conversion trigger, falling edge acts.
    input wire logic LOAD_N_I,              // Low: random address mode.
    input wire logic CLEAR_N_I,             // Low: next trigger resets to channel 0.
    input wire logic MUX_EN_I,              // High connects the addressed channel.
    input wire logic [3:0] CHAN_ADDR_I,     // Channel address in, bit3 weighs 8.
    input wire logic [2:0] OE_N_I,          // Nibble output enables, active low.
    input wire logic [11:0] SAMPLE_I,       // Converter input code, signed if bipolar.
    output logic EOC_O,                     // Conversion status, high while converting.
    output logic [3:0] CHAN_ADDR_O,         // Channel address readback.
    output logic [15:0] CHAN_SEL_O,         // One-hot channel switch drive.
    output logic HOLD_O,                    // Sampler in hold.
    output logic CONV_CLK_EN_O,             // Internal conversion clock gate.
    output logic CONV_START_O,              // One-cycle start-convert pulse.
    output logic [11:0] DATA_O,             // Result data.
    output logic [11:0] DATA_OE_N_O,        // Result pin enables, low drives.
    input wire logic [3:0] avs_address,     // Avalon byte address.
    input wire logic avs_read,              // Avalon read.
    input wire logic avs_write,             // Avalon write.
    input wire logic [31:0] avs_writedata,  // Avalon write data.
    output logic [31:0] avs_readdata,       // Avalon read data.
    output logic avs_waitrequest            // Avalon wait request.
);

    ////////////////////////////////////////////////////////////////////////////
    // Register map, 32-bit words only, no byte enables.
    // CTRL rw: [0] bipolar coding, [1] soft trigger (reads 0), [15:8] extra us.
    // STATUS ro: [0] status, [2:1] state, [7:4] channel, [8] mux enable pin.
    // RESULT ro: [11:0] last result, [19:16] its channel.
    // COUNT ro: [15:0] conversions done, wraps at the top.
    // Unmapped reads return zero and writes to read-only words are dropped.

    // Wide enough for the base time plus the largest extra time.
    localparam int ACQ_CNT_W = 9;
    localparam logic [ACQ_EXTRA_W-1:0] ACQ_EXTRA_RST =
        ACQ_EXTRA_W'(ACQ_DELAY_OHMS / ACQ_OHMS_PER_US);
    localparam logic [3:0] CHAN_MASK = 4'(NUM_CHAN - 1);
    localparam logic [3:0] STEP_LAST = 4'(RES_BITS - 1);

    generate
        if (NUM_CHAN != 8 && NUM_CHAN != 16) begin : g_bad_chan
            $error("NUM_CHAN must be 8 or 16");
        end
        if (ACQ_DELAY_OHMS < 0 || ACQ_DELAY_OHMS / ACQ_OHMS_PER_US > 255) begin : g_bad_acq
            $error("ACQ_DELAY_OHMS out of range");
        end
        if (US_CYC < 1 || CONV_STEP_CYC < 1) begin : g_bad_clk
            $error("clock too slow for the microsecond and step ticks");
        end
        if (CONV_STEP_CYC * RES_BITS > CONV_MAX_CYC) begin : g_bad_conv
            $error("conversion steps exceed the conversion limit");
        end
        if (ACQ_BASE_US + 255 >= (1 << ACQ_CNT_W)) begin : g_bad_acq_w
            $error("acquisition counter too narrow");
        end
        if (RES_BITS != 12) begin : g_bad_res
            $error("step counter and result are sized for 12 bits");
        end
    endgenerate

    typedef struct packed {
        // Sequencer.
        seq_state_t st;
        logic strobe_prev;
        logic [3:0] chan;
        logic [15:0] chan_sel;
        logic eoc;
        logic hold;
        logic clk_en;
        logic conv_start;
        logic [ACQ_CNT_W-1:0] acq_us;

        // Converter.
        logic [11:0] held;
        logic [11:0] sar;
        logic [3:0] step;
        logic [11:0] result;
        logic [3:0] result_chan;
        logic [11:0] oe_n;

        // Register file and bus.
        logic bipolar;
        logic [ACQ_EXTRA_W-1:0] acq_extra;
        logic [15:0] conv_cnt;
        logic wait_req;
        logic [31:0] rdata;
    } seq_regs_t;

    seq_regs_t s_reg;
    seq_regs_t s_next;

    // One-cycle enables from the dividers; no second clock exists.
    logic us_tick;
    logic step_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Microsecond one-shot base and gated conversion clock.
    tick_divider #(.PERIOD(US_CYC)) u_us_tick (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .en_i(s_reg.st == ST_ACQ),
        .tick_o(us_tick)
    );

    // The step tick only runs while the conversion clock is gated on.
    tick_divider #(.PERIOD(CONV_STEP_CYC)) u_conv_clk (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .en_i(s_reg.clk_en),
        .tick_o(step_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic trig;
        logic bus_req;
        logic bus_wr;
        logic [3:0] new_chan;
        logic [ACQ_CNT_W-1:0] acq_target;
        logic [11:0] coded;
        trig = 1'b0;
        bus_req = avs_read || avs_write;
        bus_wr = 1'b0;
        new_chan = s_reg.chan;
        // The extra time stands for the external delay resistance, one us per kilohm.
        acq_target = ACQ_CNT_W'(ACQ_BASE_US) + ACQ_CNT_W'(s_reg.acq_extra);

        // Bipolar samples arrive as two's complement; flipping the MSB gives offset binary.
        if (s_reg.bipolar) begin
            coded = SAMPLE_I ^ BIPOLAR_MSB_MASK;
        end else begin
            coded = SAMPLE_I;
        end

        s_next = s_reg;
        s_next.strobe_prev = STROBE_N_I;
        s_next.conv_start = 1'b0;

        ////////////////////////////////////////////////////////////////////////
        // Bus: one wait cycle, then waitrequest low for exactly one cycle.
        // The master holds its request through the wait cycle, so the decode
        // below runs once per access and the answer is registered with the
        // acknowledge.
        s_next.wait_req = 1'b1;
        if (bus_req && s_reg.wait_req) begin
            s_next.wait_req = 1'b0;
            // Read data is registered so it stands with waitrequest low.
            s_next.rdata = 32'h0000_0000;
            if (avs_address == REG_CTRL_OFS) begin
                s_next.rdata[CTRL_BIPOLAR_BIT] = s_reg.bipolar;
                s_next.rdata[CTRL_ACQ_EXTRA_LSB +: ACQ_EXTRA_W] = s_reg.acq_extra;
            end else if (avs_address == REG_STATUS_OFS) begin
                s_next.rdata[STAT_EOC_BIT] = s_reg.eoc;
                s_next.rdata[STAT_STATE_LSB +: 2] = s_reg.st;
                s_next.rdata[STAT_CHAN_LSB +: 4] = s_reg.chan;
                s_next.rdata[STAT_MUX_EN_BIT] = MUX_EN_I;
            end else if (avs_address == REG_RESULT_OFS) begin
                s_next.rdata[11:0] = s_reg.result;
                s_next.rdata[RES_CHAN_LSB +: 4] = s_reg.result_chan;
            end else if (avs_address == REG_COUNT_OFS) begin
                s_next.rdata[15:0] = s_reg.conv_cnt;
            end
        end

        // A write lands only in the acknowledge cycle, so it is never applied twice.
        bus_wr = avs_write && !s_reg.wait_req;
        if (bus_wr && avs_address == REG_CTRL_OFS) begin
            s_next.bipolar = avs_writedata[CTRL_BIPOLAR_BIT];
            s_next.acq_extra = avs_writedata[CTRL_ACQ_EXTRA_LSB +: ACQ_EXTRA_W];
            // The soft trigger is a one-cycle strobe and reads back as zero.
            trig = avs_writedata[CTRL_SOFT_TRIG_BIT];
        end

        ////////////////////////////////////////////////////////////////////////
        // Pin trigger acts on its falling edge only.
        if (s_reg.strobe_prev && !STROBE_N_I) begin
            trig = 1'b1;
        end


        ////////////////////////////////////////////////////////////////////////
        case (s_reg.st)
            ST_IDLE: begin
                // Edges during a running sequence are ignored: one conversion per edge.
                if (trig) begin
                    // Clear overrides load; load overrides the sequential step.
                    if (!CLEAR_N_I) begin
                        new_chan = CHAN_RST;
                    end else if (!LOAD_N_I) begin
                        new_chan = CHAN_ADDR_I & CHAN_MASK;
                    end else begin
                        new_chan = (s_reg.chan + 4'h1) & CHAN_MASK;
                    end
                    s_next.chan = new_chan;
                    s_next.st = ST_ACQ;
                    s_next.eoc = 1'b0;
                    s_next.hold = 1'b0;
                    s_next.acq_us = '0;
                end
            end

            ST_ACQ: begin
                // The divider restarts on entry, so every counted microsecond is whole.
                if (us_tick) begin
                    s_next.acq_us = s_reg.acq_us + 1'b1;
                    if (s_reg.acq_us + 1'b1 == acq_target) begin
                        s_next.st = ST_CONV;
                        s_next.hold = 1'b1;
                        s_next.clk_en = 1'b1;
                        s_next.conv_start = 1'b1;
                        s_next.eoc = 1'b1;
                        // The sample is frozen here; later input changes cannot reach it.
                        s_next.held = coded;
                        s_next.sar = 12'h000;
                        s_next.step = STEP_LAST;
                    end
                end
            end

            ST_CONV: begin
                // Twelve steps of the gated clock fit inside the conversion limit.
                // Bits are resolved from the top down, one per step tick.
                if (step_tick) begin
                    s_next.sar[s_reg.step] = s_reg.held[s_reg.step];
                    s_next.step = s_reg.step - 4'h1;
                    if (s_reg.step == 4'h0) begin
                        s_next.st = ST_IDLE;
                        s_next.eoc = 1'b0;
                        s_next.clk_en = 1'b0;
                        s_next.hold = 1'b0;
                        // The last step's bit is merged straight into the result.
                        s_next.result = s_reg.sar | (s_reg.held & 12'h001);
                        s_next.result_chan = s_reg.chan;
                        s_next.conv_cnt = s_reg.conv_cnt + 16'h0001;
                    end
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase


        ////////////////////////////////////////////////////////////////////////
        // Switch drive follows the address being loaded, so both change at one edge.
        s_next.chan_sel = 16'h0000;
        if (MUX_EN_I) begin
            s_next.chan_sel[s_next.chan] = 1'b1;
        end

        // Each nibble's enable is registered, so its pins follow one cycle later.
        s_next.oe_n[3:0] = {4{OE_N_I[0]}};
        s_next.oe_n[7:4] = {4{OE_N_I[1]}};
        s_next.oe_n[11:8] = {4{OE_N_I[2]}};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset loads constants only; afterwards the struct registers as a whole.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_reg.st <= ST_IDLE;
            s_reg.strobe_prev <= 1'b1;
            s_reg.chan <= CHAN_RST;
            s_reg.chan_sel <= 16'h0000;
            s_reg.eoc <= 1'b0;
            s_reg.hold <= 1'b0;
            s_reg.clk_en <= 1'b0;
            s_reg.conv_start <= 1'b0;
            s_reg.acq_us <= '0;

            s_reg.held <= RESULT_RST;
            s_reg.sar <= RESULT_RST;
            s_reg.step <= 4'h0;
            s_reg.result <= RESULT_RST;
            s_reg.result_chan <= CHAN_RST;
            s_reg.oe_n <= 12'hfff;

            s_reg.bipolar <= BIPOLAR_RST;
            s_reg.acq_extra <= ACQ_EXTRA_RST;
            s_reg.conv_cnt <= 16'h0000;
            s_reg.wait_req <= 1'b1;
            s_reg.rdata <= 32'h0000_0000;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every output is a field of the state register, so none is combinational.
    assign EOC_O = s_reg.eoc;
    assign CHAN_ADDR_O = s_reg.chan;
    assign CHAN_SEL_O = s_reg.chan_sel;
    assign HOLD_O = s_reg.hold;
    assign CONV_CLK_EN_O = s_reg.clk_en;
    assign CONV_START_O = s_reg.conv_start;
    assign DATA_O = s_reg.result;
    assign DATA_OE_N_O = s_reg.oe_n;
    assign avs_readdata = s_reg.rdata;
    assign avs_waitrequest = s_reg.wait_req;

endmodule // daq_acquire_convert_sequencer

// ---- test/daq_seq_chk.sv ----
// Port-level assertions for the acquire-and-convert sequencer.
`timescale 1ns/10ps
module daq_seq_chk
    import daq_seq_pkg::*;
#(
    parameter int NUM_CHAN = 16
) (
    input wire logic CLK_I, // Clock.
    input wire logic RESET_N_I, // Reset.
    input wire logic STROBE_N_I, // Trigger.
    input wire logic LOAD_N_I, // Load mode.
    input wire logic CLEAR_N_I, // Clear mode.
    input wire logic MUX_EN_I, // Mux enable.
    input wire logic [3:0] CHAN_ADDR_I, // Address in.
    input wire logic [2:0] OE_N_I, // Nibble enables.
    input wire logic EOC_O, // Status.
    input wire logic [3:0] CHAN_ADDR_O, // Address out.
    input wire logic [15:0] CHAN_SEL_O, // Switches.
    input wire logic HOLD_O, // Hold.
    input wire logic CONV_CLK_EN_O, // Clock gate.
    input wire logic CONV_START_O, // Start pulse.
    input wire logic [11:0] DATA_O, // Result.
    input wire logic [11:0] DATA_OE_N_O // Pin enables.
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // Run lengths of the status level; the low count saturates so a long idle cannot wrap.
    logic [11:0] hi_cnt;
    logic [11:0] lo_cnt;
    logic [3:0] mask;
    assign mask = 4'(NUM_CHAN - 1);
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            hi_cnt <= 12'h000;
            lo_cnt <= 12'h000;
        end else begin
            hi_cnt <= EOC_O ? hi_cnt + 12'h001 : 12'h000;
            lo_cnt <= EOC_O ? 12'h000 : lo_cnt + {11'h000, ~&lo_cnt};
        end
    end
    a_start_on_rise: assert property ($rose(EOC_O) |-> CONV_START_O && HOLD_O && CONV_CLK_EN_O)
        else $error("status rose without hold, clock gate and start");
    a_start_once: assert property (CONV_START_O |=> !CONV_START_O && EOC_O)
        else $error("start pulse longer than one cycle");
    a_conv_bound: assert property (hi_cnt < 12'(CONV_MAX_CYC))
        else $error("conversion too long");
    a_acq_floor: assert property ($rose(EOC_O) |-> lo_cnt >= 12'(ACQ_BASE_US * US_CYC - 1))
        else $error("acquisition too short");
    a_fall_release: assert property ($fell(EOC_O) |-> !HOLD_O && !CONV_CLK_EN_O)
        else $error("hold or clock gate left on after conversion");
    a_result_held: assert property (!$fell(EOC_O) |-> $stable(DATA_O))
        else $error("result changed outside completion");
    a_addr_cause: assert property ($changed(CHAN_ADDR_O) |-> $past(STROBE_N_I, 2) &&
        !$past(STROBE_N_I) && (!$past(CLEAR_N_I) ? CHAN_ADDR_O == 4'h0 : !$past(LOAD_N_I) ?
        CHAN_ADDR_O == ($past(CHAN_ADDR_I) & mask) : CHAN_ADDR_O == (($past(CHAN_ADDR_O) + 4'h1) & mask)))
        else $error("address changed without matching trigger");
    a_sel_follow: assert property ($past(RESET_N_I) |-> CHAN_SEL_O ==
        ($past(MUX_EN_I) ? 16'h0001 << CHAN_ADDR_O : 16'h0000))
        else $error("channel switches disagree with address or enable");
    a_oe_follow: assert property ($past(RESET_N_I) |-> DATA_OE_N_O == {{4{$past(OE_N_I[2])}},
        {4{$past(OE_N_I[1])}}, {4{$past(OE_N_I[0])}}})
        else $error("result pin enables disagree with nibble enables");
endmodule // daq_seq_chk
bind daq_acquire_convert_sequencer daq_seq_chk #(.NUM_CHAN(NUM_CHAN)) daq_seq_chk_i (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .STROBE_N_I(STROBE_N_I), .LOAD_N_I(LOAD_N_I),
    .CLEAR_N_I(CLEAR_N_I), .MUX_EN_I(MUX_EN_I), .CHAN_ADDR_I(CHAN_ADDR_I), .OE_N_I(OE_N_I),
    .EOC_O(EOC_O), .CHAN_ADDR_O(CHAN_ADDR_O), .CHAN_SEL_O(CHAN_SEL_O), .HOLD_O(HOLD_O),
    .CONV_CLK_EN_O(CONV_CLK_EN_O), .CONV_START_O(CONV_START_O), .DATA_O(DATA_O),
    .DATA_OE_N_O(DATA_OE_N_O));

// ---- test/host_model.sv ----
// Host-side model: trigger pulses, address pins and status feedback.
`timescale 1ns/10ps
module host_model (
    input wire logic clk_i, // Clock.
    input wire logic trig_i, // Request one trigger pulse.
    input wire logic loop_i, // Feed status back to trigger.
    input wire logic eoc_i, // Status from the device.
    input wire logic [3:0] addr_i, // Address to present.
    output logic strobe_n_o, // Trigger, active low.
    output logic [3:0] chan_addr_o // Address pins.
);
    logic [2:0] cnt = 3'h0;
    initial begin
        strobe_n_o = 1'b1;
        chan_addr_o = 4'h0;
    end
    always @(posedge clk_i) begin
        cnt <= trig_i ? 3'h6 : cnt - {2'h0, |cnt};
        // Outside the setup and hold span the pins show the inverse, so a late capture shows.
        chan_addr_o <= (trig_i || cnt != 3'h0) ? addr_i : ~addr_i;
        strobe_n_o <= loop_i ? eoc_i : !(cnt == 3'h4 || cnt == 3'h3);
    end
endmodule // host_model

// ---- test/testbench.sv ----
// Self-checking bench for the acquire-and-convert sequencer.
`timescale 1ns/10ps
module testbench;
    import daq_seq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic load_n = 1'b0;
    logic clear_n = 1'b1;
    logic mux_en = 1'b1;
    logic trig = 1'b0;
    logic loop = 1'b0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [2:0] oe_n = 3'h0;
    logic [3:0] addr = 4'h0;
    logic [3:0] av_a = 4'h0;
    logic [11:0] sample = 12'h000;
    logic [31:0] av_wd = 32'h00000000;
    logic strobe_n, eoc, wait_rq;
    logic [3:0] ch_in, ch_out;
    logic [15:0] sel;
    logic [11:0] data, data_oe_n, last;
    logic [31:0] rdata, rd;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    daq_acquire_convert_sequencer daq_acquire_convert_sequencer_i (
        .CLK_I(clk), .RESET_N_I(rst_n), .STROBE_N_I(strobe_n), .LOAD_N_I(load_n),
        .CLEAR_N_I(clear_n), .MUX_EN_I(mux_en), .CHAN_ADDR_I(ch_in), .OE_N_I(oe_n),
        .SAMPLE_I(sample), .EOC_O(eoc), .CHAN_ADDR_O(ch_out), .CHAN_SEL_O(sel), .HOLD_O(),
        .CONV_CLK_EN_O(), .CONV_START_O(), .DATA_O(data), .DATA_OE_N_O(data_oe_n),
        .avs_address(av_a), .avs_read(av_rd), .avs_write(av_wr), .avs_writedata(av_wd),
        .avs_readdata(rdata), .avs_waitrequest(wait_rq));
    host_model host_model_i (.clk_i(clk), .trig_i(trig), .loop_i(loop), .eoc_i(eoc),
        .addr_i(addr), .strobe_n_o(strobe_n), .chan_addr_o(ch_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 50000) begin
            errors++;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // The request stands until waitrequest is seen low at a rising edge; data is taken there.
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        av_a <= a;
        av_wd <= d;
        av_wr <= wr;
        av_rd <= !wr;
        do @(posedge clk); while (wait_rq !== 1'b0);
        rd = rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task automatic wait_eoc(input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (eoc !== lvl);
    endtask
    task automatic pulse(input logic [3:0] a, input logic [11:0] s);
        @(posedge clk);
        addr <= a;
        sample <= s;
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
    endtask
    task automatic conv(input logic [3:0] a, input logic [11:0] s, input logic [3:0] ea,
            input logic [11:0] ed);
        int n;
        pulse(a, s);
        do @(negedge clk); while (strobe_n !== 1'b0);
        wait_eoc(1'b1, n);
        check(n >= US_CYC * ACQ_BASE_US && n <= US_CYC * ACQ_BASE_US + 3, 1'b1);
        check(ch_out, ea);
        check(data, last);
        wait_eoc(1'b0, n);
        check(n <= CONV_MAX_CYC, 1'b1);
        check(data, ed);
        last = ed;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic regs_and_pins;
        last = 12'h000;
        check(eoc, 1'b0);
        check(ch_out, 4'h0);
        av(1'b0, REG_CTRL_OFS, 32'h00000000);
        check(rd, 32'h00000000);
        av(1'b1, REG_STATUS_OFS, 32'hffffffff);
        av(1'b0, REG_STATUS_OFS, 32'h00000000);
        check(rd, 32'h00000100);
        av(1'b1, 4'h2, 32'hffffffff);
        av(1'b0, 4'h2, 32'h00000000);
        check(rd, 32'h00000000);
        @(posedge clk);
        oe_n <= 3'b010;
        mux_en <= 1'b0;
        repeat (2) @(negedge clk);
        check(data_oe_n, 12'h0f0);
        check(sel, 16'h0000);
        @(posedge clk);
        oe_n <= 3'h0;
        mux_en <= 1'b1;
        repeat (2) @(negedge clk);
        check(sel, 16'h0001);
    endtask
    task automatic load_seq;
        conv(4'h5, 12'h000, 4'h5, 12'h000);
        @(posedge clk);
        load_n <= 1'b1;
        conv(4'h9, 12'hfff, 4'h6, 12'hfff);
        @(posedge clk);
        load_n <= 1'b0;
        conv(4'hf, 12'h7ff, 4'hf, 12'h7ff);
        @(posedge clk);
        load_n <= 1'b1;
        conv(4'h3, 12'h001, 4'h0, 12'h001);
    endtask
    task automatic busy_ignored;
        int n;
        pulse(4'h9, 12'h123);
        wait_eoc(1'b1, n);
        pulse(4'h9, 12'h456);
        wait_eoc(1'b0, n);
        repeat (40) @(negedge clk);
        check(eoc, 1'b0);
        check(ch_out, 4'h1);
        check(data, 12'h123);
        last = 12'h123;
    endtask
    task automatic bipolar_clear;
        av(1'b1, REG_CTRL_OFS, 32'h00000001);
        @(posedge clk);
        clear_n <= 1'b0;
        conv(4'h7, 12'h800, 4'h0, 12'h000);
        conv(4'h7, 12'h000, 4'h0, 12'h800);
        conv(4'h7, 12'h7ff, 4'h0, 12'hfff);
    endtask
    task automatic soft_and_count;
        int n;
        av(1'b1, REG_CTRL_OFS, 32'h00000003);
        wait_eoc(1'b1, n);
        check(n >= US_CYC * ACQ_BASE_US && n <= US_CYC * ACQ_BASE_US + 3, 1'b1);
        wait_eoc(1'b0, n);
        check(n <= CONV_MAX_CYC, 1'b1);
        check(data, 12'hfff);
        check(ch_out, 4'h0);
        av(1'b0, REG_RESULT_OFS, 32'h00000000);
        check(rd, 32'h00000fff);
        av(1'b0, REG_COUNT_OFS, 32'h00000000);
        check(rd, 32'h00000009);
        av(1'b0, REG_CTRL_OFS, 32'h00000000);
        check(rd, 32'h00000001);
        last = 12'hfff;
    endtask
    task automatic free_run;
        int n;
        @(posedge clk);
        loop <= 1'b1;
        repeat (3) begin
            wait_eoc(1'b1, n);
            check(ch_out, 4'h0);
            wait_eoc(1'b0, n);
            check(n <= CONV_MAX_CYC, 1'b1);
        end
        wait_eoc(1'b1, n);
        @(posedge clk);
        loop <= 1'b0;
        wait_eoc(1'b0, n);
        repeat (40) @(negedge clk);
        check(eoc, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        regs_and_pins;
        load_seq;
        busy_ignored;
        bipolar_clear;
        soft_and_count;
        free_run;
        tally_and_finish;
    end
endmodule // testbench
